// ---- core/batch_mix_sequencer.sv ----
// batch mixing sequencer: selectors, batch phases, timers, alarm, registers
//
// Summary of operation
// - system on: low level starts a batch, high level ends filling
// - system remote: same sequencing, enabled only while run contact closed
// - speed source picks panel speed or current-loop speed for feeder
// - water on: valve open always, high level ignored
// - water auto: valve opens when a batch begins
// - high level in a batch closes auto valve, stops auto feeder
// - feeder on: runs at once until selector leaves on
// - feeder auto: starts with batch, runs only while flow is present
// - feed time accumulates over flow gaps; auto feeder stops at preset
// - mixer on: runs at once, never stopped automatically
// - mixer auto: starts at batch begin, runs through the fill
// - high level starts mix off-delay; mixer stops at expiry, batch ends
// - vibrator on: runs at once until selector leaves on
// - vibrator auto: runs only with feeder, cycled on and off by timer
// - hopper low lights its lamp and sets its interrupt event, affects no sequencing
// - alarm rises on low water flow during the fill phase only
// - acknowledge clears alarm; while low flow persists the alarm stays set
`timescale 1ns/10ps
module batch_mix_sequencer #(
  parameter int unsigned TICK_CYCLES_P = batch_mix_pkg::TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [1:0] i_sys_sel,
  input wire logic [1:0] i_water_sel,
  input wire logic [1:0] i_feeder_sel,
  input wire logic [1:0] i_mixer_sel,
  input wire logic [1:0] i_vib_sel,
  input wire logic i_speed_src,
  input wire logic [batch_mix_pkg::SPEED_W-1:0] i_local_speed,
  input wire logic [batch_mix_pkg::SPEED_W-1:0] i_remote_speed,
  input wire logic i_low_level,
  input wire logic i_high_level,
  input wire logic i_flow,
  input wire logic i_run_contact,
  input wire logic i_hopper_low,
  input wire logic i_alarm_ack,
  input wire logic [batch_mix_pkg::ADDR_W-1:0] i_addr,
  input wire logic [batch_mix_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [batch_mix_pkg::DATA_W-1:0] o_rdata,
  output logic [batch_mix_pkg::SPEED_W-1:0] o_feeder_speed,
  output logic o_water_valve,
  output logic o_feeder,
  output logic o_mixer,
  output logic o_vibrator,
  output logic o_alarm,
  output logic o_hopper_lamp,
  output logic o_irq
);
  import batch_mix_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);

  typedef struct packed {
    batch_e phase;
    logic water;
    logic feeder;
    logic mixer;
    logic vib;
    logic alarm;
    logic lamp;
    logic [SPEED_W-1:0] speed;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [TIME_W-1:0] feed_time;
    logic [TIME_W-1:0] mix_time;
    logic [TIME_W-1:0] vib_on;
    logic [TIME_W-1:0] vib_off;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [DATA_W-1:0] rdata;
  } seq_s;

  seq_s r;
  seq_s next_r;

  logic enabled;
  logic start_batch;
  logic low_flow;
  logic feed_run;
  logic feed_done;
  logic mix_done;
  logic vib_cycle;
  logic [TIME_W-1:0] feed_count;
  logic [TIME_W-1:0] mix_count;

  ////////////////////////////////////////////////////////////////////////////
  // batch enable and start

  // remote mode waits on the contact, off mode blocks all batch sequencing
  assign enabled = (i_sys_sel == SYS_ON) ||
                   ((i_sys_sel == SYS_REMOTE) && i_run_contact);

  assign start_batch = (r.phase == PH_IDLE) && enabled && i_low_level;

  // auto feeder running time is all the feed timer counts
  assign feed_run = r.feeder && (i_feeder_sel == SEL_AUTO) && (r.phase == PH_FILL);

  assign low_flow = (r.phase == PH_FILL) && !i_flow;

  ////////////////////////////////////////////////////////////////////////////
  // timers

  preset_timer u_feed_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(start_batch),
    .i_run(feed_run),
    .i_tick(r.tick),
    .i_preset(r.feed_time),
    .o_count(feed_count),
    .o_done(feed_done)
  );

  preset_timer u_mix_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(r.phase != PH_MIX),
    .i_run(1'b1),
    .i_tick(r.tick),
    .i_preset(r.mix_time),
    .o_count(mix_count),
    .o_done(mix_done)
  );

  vib_cycler u_vib_cycler (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(r.feeder),
    .i_tick(r.tick),
    .i_on_time(r.vib_on),
    .i_off_time(r.vib_off),
    .o_on(vib_cycle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] w1c;
    logic [DATA_W-1:0] st;
    events = '0;
    w1c = '0;
    st = '0;
    next_r = r;

    // one-second tick; presets are all in seconds
    next_r.tick = 1'b0;
    if (r.tick_cnt >= TICK_LAST) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 1'b1;
    end

    unique case (r.phase)
      PH_IDLE: begin
        if (start_batch) begin
          next_r.phase = PH_FILL;
        end
      end
      PH_FILL: begin
        if (!enabled) begin
          next_r.phase = PH_IDLE;
        end else if (i_high_level) begin
          next_r.phase = PH_MIX;
        end
      end
      PH_MIX: begin
        if (!enabled || mix_done) begin
          next_r.phase = PH_IDLE;
        end
      end
    endcase

    case (i_water_sel)
      SEL_ON: next_r.water = 1'b1;
      SEL_AUTO: next_r.water = (next_r.phase == PH_FILL);
      default: next_r.water = 1'b0;
    endcase

    // a fresh batch must not see the previous batch's done flag
    case (i_feeder_sel)
      SEL_ON: next_r.feeder = 1'b1;
      SEL_AUTO: next_r.feeder = (next_r.phase == PH_FILL) && i_flow &&
                                (start_batch || !feed_done);
      default: next_r.feeder = 1'b0;
    endcase

    case (i_mixer_sel)
      SEL_ON: next_r.mixer = 1'b1;
      SEL_AUTO: next_r.mixer = (next_r.phase != PH_IDLE);
      default: next_r.mixer = 1'b0;
    endcase

    case (i_vib_sel)
      SEL_ON: next_r.vib = 1'b1;
      SEL_AUTO: next_r.vib = vib_cycle;
      default: next_r.vib = 1'b0;
    endcase

    // a new low-flow condition wins over an acknowledge in the same cycle
    if (low_flow) begin
      next_r.alarm = 1'b1;
    end else if (i_alarm_ack) begin
      next_r.alarm = 1'b0;
    end

    next_r.lamp = i_hopper_low;
    next_r.speed = (i_speed_src == SPEED_LOCAL) ? i_local_speed : i_remote_speed;

    events[EV_BATCH_START] = start_batch;
    events[EV_BATCH_END] = (r.phase == PH_MIX) && mix_done;
    events[EV_LOW_FLOW] = low_flow && !r.alarm;
    events[EV_HOPPER_LOW] = i_hopper_low && !r.lamp;

    if (i_wr) begin
      case (i_addr)
        REG_FEED_TIME: next_r.feed_time = i_wdata[TIME_W-1:0];
        REG_MIX_TIME: next_r.mix_time = i_wdata[TIME_W-1:0];
        REG_VIB_ON: next_r.vib_on = i_wdata[TIME_W-1:0];
        REG_VIB_OFF: next_r.vib_off = i_wdata[TIME_W-1:0];
        REG_IRQ_STATUS: w1c = i_wdata[EV_W-1:0];
        REG_IRQ_MASK: next_r.mask = i_wdata[EV_W-1:0];
        default: w1c = '0;
      endcase
    end
    // set wins over write-one-to-clear
    next_r.status = (r.status & ~w1c) | events;

    st[ST_PHASE +: 2] = r.phase;
    st[ST_WATER] = r.water;
    st[ST_FEEDER] = r.feeder;
    st[ST_MIXER] = r.mixer;
    st[ST_VIB] = r.vib;
    st[ST_ALARM] = r.alarm;
    st[ST_LAMP] = r.lamp;
    st[ST_FEED_CNT +: TIME_W] = feed_count;

    // read data stand for one cycle only; unmapped reads give zero
    next_r.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        REG_FEED_TIME: next_r.rdata = {16'h0000, r.feed_time};
        REG_MIX_TIME: next_r.rdata = {16'h0000, r.mix_time};
        REG_VIB_ON: next_r.rdata = {16'h0000, r.vib_on};
        REG_VIB_OFF: next_r.rdata = {16'h0000, r.vib_off};
        REG_IRQ_STATUS: next_r.rdata = {28'h0000000, r.status};
        REG_IRQ_MASK: next_r.rdata = {28'h0000000, r.mask};
        REG_STATE: next_r.rdata = st;
        default: next_r.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
      r.phase <= PH_IDLE;
      r.feed_time <= FEED_TIME_RST;
      r.mix_time <= MIX_TIME_RST;
      r.vib_on <= VIB_ON_RST;
      r.vib_off <= VIB_OFF_RST;
      r.mask <= IRQ_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_feeder_speed = r.speed;
  assign o_water_valve = r.water;
  assign o_feeder = r.feeder;
  assign o_mixer = r.mixer;
  assign o_vibrator = r.vib;
  assign o_alarm = r.alarm;
  assign o_hopper_lamp = r.lamp;
  assign o_irq = |(r.status & r.mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_batch_begin;
    start_batch;
  endsequence

  sequence s_high_in_fill;
    (r.phase == PH_FILL) && enabled && i_high_level;
  endsequence

  property p_fill_then_mix;
    s_high_in_fill |=> (r.phase == PH_MIX) ##0 o_mixer || (i_mixer_sel != SEL_AUTO);
  endproperty

  a_batch_opens: assert property (s_batch_begin and (i_water_sel == SEL_AUTO)
    |=> o_water_valve && (r.phase == PH_FILL))
    else $error("auto valve did not open at batch start");

  a_remote_gate: assert property ((i_sys_sel == SYS_REMOTE) && !i_run_contact
    && (r.phase == PH_IDLE) |=> (r.phase == PH_IDLE))
    else $error("batch started with remote contact open");

  a_sys_off_idle: assert property ((i_sys_sel == SYS_OFF)
    |=> (r.phase == PH_IDLE))
    else $error("sequencing active with system off");

  a_off_holds: assert property ((i_water_sel == SEL_OFF) && (i_feeder_sel == SEL_OFF)
    && (i_mixer_sel == SEL_OFF) |=> !o_water_valve && !o_feeder && !o_mixer)
    else $error("output energised with selector off");

  a_water_manual: assert property ((i_water_sel == SEL_ON) && i_high_level
    |=> o_water_valve)
    else $error("manual valve closed");

  a_high_stops: assert property (s_high_in_fill and ((i_water_sel == SEL_AUTO)
    && (i_feeder_sel == SEL_AUTO)) |=> !o_water_valve && !o_feeder)
    else $error("high level did not stop fill and feed");

  a_mix_follows: assert property (p_fill_then_mix)
    else $error("mix off-delay not entered at high level");

  a_mix_expiry: assert property ((r.phase == PH_MIX) && mix_done
    && (i_mixer_sel == SEL_AUTO) |=> !o_mixer && (r.phase == PH_IDLE))
    else $error("mixer kept running after mix time");

  a_mixer_fill: assert property ((r.phase == PH_FILL) && (i_mixer_sel == SEL_AUTO)
    && !i_high_level && enabled |=> o_mixer)
    else $error("auto mixer off during fill");

  a_manual_run: assert property ((i_feeder_sel == SEL_ON) && (i_mixer_sel == SEL_ON)
    && (i_vib_sel == SEL_ON) |=> o_feeder && o_mixer && o_vibrator)
    else $error("manual output not running");

  a_feed_flow: assert property ((i_feeder_sel == SEL_AUTO) && !i_flow
    |=> !o_feeder)
    else $error("auto feeder ran without flow");

  a_feed_limit: assert property ((i_feeder_sel == SEL_AUTO) && feed_done
    && !start_batch |=> !o_feeder)
    else $error("auto feeder ran past feed time");

  a_feed_hold: assert property ((r.phase == PH_FILL) && !feed_run && !start_batch
    |=> feed_count == $past(feed_count))
    else $error("feed time moved while feeder stopped");

  a_vib_interlock: assert property ((i_vib_sel == SEL_AUTO) && !o_feeder
    |=> !o_vibrator)
    else $error("auto vibrator ran without feeder");

  a_lamp_only: assert property (1'b1 |=> o_hopper_lamp == $past(i_hopper_low))
    else $error("hopper lamp does not follow sensor");

  a_alarm_raise: assert property (low_flow |=> o_alarm)
    else $error("low flow alarm missed");

  a_alarm_clear: assert property (i_alarm_ack && !low_flow |=> !o_alarm)
    else $error("alarm not cleared by acknowledge");

  // the edge that releases reset still loads reset values, so skip it
  a_speed_pick: assert property (!i_rst |=> o_feeder_speed ==
    ($past(i_speed_src) ? $past(i_remote_speed) : $past(i_local_speed)))
    else $error("feeder speed from wrong source");

endmodule // batch_mix_sequencer

// ---- inc/batch_mix_pkg.sv ----
// constants and types shared by the batch mixing sequencer
package batch_mix_pkg;
  localparam logic [1:0] SYS_OFF = 2'h0;
  localparam logic [1:0] SYS_ON = 2'h1;
  localparam logic [1:0] SYS_REMOTE = 2'h2;
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ON = 2'h1;
  localparam logic [1:0] SEL_AUTO = 2'h2;
  localparam logic SPEED_LOCAL = 1'h0;
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int TICK_W = 24;
  localparam int TIME_W = 16;
  localparam int SPEED_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EV_W = 4;
  localparam logic [ADDR_W-1:0] REG_FEED_TIME = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MIX_TIME = 8'h04;
  localparam logic [ADDR_W-1:0] REG_VIB_ON = 8'h08;
  localparam logic [ADDR_W-1:0] REG_VIB_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h18;
  localparam logic [TIME_W-1:0] FEED_TIME_RST = 16'h003c;
  localparam logic [TIME_W-1:0] MIX_TIME_RST = 16'h012c;
  localparam logic [TIME_W-1:0] VIB_ON_RST = 16'h0005;
  localparam logic [TIME_W-1:0] VIB_OFF_RST = 16'h000a;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam int EV_BATCH_START = 0;
  localparam int EV_BATCH_END = 1;
  localparam int EV_LOW_FLOW = 2;
  localparam int EV_HOPPER_LOW = 3;
  localparam int ST_PHASE = 0;
  localparam int ST_WATER = 2;
  localparam int ST_FEEDER = 3;
  localparam int ST_MIXER = 4;
  localparam int ST_VIB = 5;
  localparam int ST_ALARM = 6;
  localparam int ST_LAMP = 7;
  localparam int ST_FEED_CNT = 16;
  typedef enum logic [1:0] {PH_IDLE, PH_FILL, PH_MIX} batch_e;
endpackage

// ---- core/preset_timer.sv ----
// accumulating seconds timer that flags when its preset is reached
`timescale 1ns/10ps
module preset_timer (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [batch_mix_pkg::TIME_W-1:0] i_preset,
  output logic [batch_mix_pkg::TIME_W-1:0] o_count,
  output logic o_done
);
  import batch_mix_pkg::*;
  typedef struct packed {
    logic [TIME_W-1:0] count;
  } timer_s;
  timer_s r;
  timer_s next_r;
  // count holds while run is low, so interruptions accumulate
  always_comb begin
    next_r = r;
    if (i_clear) begin
      next_r.count = '0;
    end else if (i_run && i_tick && !o_done) begin
      next_r.count = r.count + 1'b1;
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign o_count = r.count;
  assign o_done = (r.count >= i_preset);
endmodule // preset_timer

// ---- core/vib_cycler.sv ----
// on/off cycling timer for the hopper vibrator
`timescale 1ns/10ps
module vib_cycler (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_tick,
  input wire logic [batch_mix_pkg::TIME_W-1:0] i_on_time,
  input wire logic [batch_mix_pkg::TIME_W-1:0] i_off_time,
  output logic o_on
);
  import batch_mix_pkg::*;
  typedef struct packed {
    logic on;
    logic [TIME_W-1:0] count;
  } cycle_s;
  cycle_s r;
  cycle_s next_r;
  logic [TIME_W-1:0] limit;
  logic [TIME_W-1:0] step;
  always_comb begin
    next_r = r;
    limit = r.on ? i_on_time : i_off_time;
    step = r.count + 1'b1;
    // every enable starts with an on phase
    if (!i_enable) begin
      next_r.on = 1'b1;
      next_r.count = '0;
    end else if (i_tick) begin
      if (step >= limit) begin
        next_r.on = !r.on;
        next_r.count = '0;
      end else begin
        next_r.count = step;
      end
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= '{on: 1'b1, count: '0};
    end else begin
      r <= next_r;
    end
  end
  assign o_on = i_enable && r.on;
endmodule // vib_cycler

// ---- bench/tank_model.sv ----
// tank, fill water supply and flow switch facing the sequencer's field outputs
`timescale 1ns/10ps
module tank_model #(
  parameter int LOW_MARK = 4,
  parameter int HIGH_MARK = 60
) (
  input wire logic i_clock,
  input wire logic i_valve,
  input wire logic i_supply,
  input wire logic i_drain,
  output logic o_low_level,
  output logic o_high_level,
  output logic o_flow
);
  int level = 0;
  // flow exists only through an open valve with supply pressure behind it
  assign o_flow = i_valve && i_supply;
  assign o_low_level = level <= LOW_MARK;
  assign o_high_level = level >= HIGH_MARK;
  // a forced-open valve overfills a little past the high switch
  always @(posedge i_clock) begin
    if (i_drain && level > 1)
      level <= level - 2;
    else if (o_flow && level < HIGH_MARK + 4)
      level <= level + 1;
  end
endmodule // tank_model

// ---- bench/tb_batch_mix_sequencer.sv ----
// self-checking testbench for the batch mixing sequencer
`timescale 1ns/10ps
module tb_batch_mix_sequencer;
  import batch_mix_pkg::*;
  logic i_clock = 0, i_rst = 1, i_speed_src = 0, i_run_contact = 0;
  logic i_hopper_low = 0, i_alarm_ack = 0, i_wr = 0, i_rd = 0;
  logic supply = 1, drain = 0;
  logic [1:0] i_sys_sel = SYS_OFF, i_water_sel = SEL_AUTO, i_feeder_sel = SEL_AUTO;
  logic [1:0] i_mixer_sel = SEL_AUTO, i_vib_sel = SEL_AUTO;
  logic [SPEED_W-1:0] i_local_speed = 8'h5a, i_remote_speed = 8'ha5;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 32'h0;
  logic [DATA_W-1:0] o_rdata;
  logic [SPEED_W-1:0] o_feeder_speed;
  logic o_water_valve, o_feeder, o_mixer, o_vibrator, o_alarm, o_hopper_lamp, o_irq;
  logic low, high, flow;
  wire [7:0] seen = {o_hopper_lamp, low, high, o_alarm, o_vibrator, o_mixer, o_feeder,
    o_water_valve};
  int err_total = 0, n_compared = 0, cycles = 0, feed_on = 0, vib_hi = 0, vib_lo = 0;

  always #50 i_clock = ~i_clock;

  batch_mix_sequencer #(.TICK_CYCLES_P(4)) batch_mix_sequencer_i (.i_clock(i_clock),
    .i_rst(i_rst), .i_sys_sel(i_sys_sel), .i_water_sel(i_water_sel),
    .i_feeder_sel(i_feeder_sel), .i_mixer_sel(i_mixer_sel), .i_vib_sel(i_vib_sel),
    .i_speed_src(i_speed_src), .i_local_speed(i_local_speed),
    .i_remote_speed(i_remote_speed), .i_low_level(low), .i_high_level(high),
    .i_flow(flow), .i_run_contact(i_run_contact), .i_hopper_low(i_hopper_low),
    .i_alarm_ack(i_alarm_ack), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_feeder_speed(o_feeder_speed),
    .o_water_valve(o_water_valve), .o_feeder(o_feeder), .o_mixer(o_mixer),
    .o_vibrator(o_vibrator), .o_alarm(o_alarm), .o_hopper_lamp(o_hopper_lamp),
    .o_irq(o_irq));

  tank_model tank_model_i (.i_clock(i_clock), .i_valve(o_water_valve), .i_supply(supply),
    .i_drain(drain), .o_low_level(low), .o_high_level(high), .o_flow(flow));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ceiling is several times the longest expected run
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (o_feeder) feed_on <= feed_on + 1;
    if (o_feeder && o_vibrator) vib_hi <= vib_hi + 1;
    if (o_feeder && !o_vibrator) vib_lo <= vib_lo + 1;
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 0;
    // the written register only settles after this edge
    @(negedge i_clock);
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 0;
    @(negedge i_clock);
    check(o_rdata, exp);
  endtask

  task automatic wait_out(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (seen[b] !== v && n < lim) begin
      @(negedge i_clock);
      n++;
    end
    check(seen[b], v);
  endtask

  task automatic ack;
    @(posedge i_clock) i_alarm_ack <= 1;
    @(posedge i_clock) i_alarm_ack <= 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst <= 0;
    rd(REG_FEED_TIME, {16'h0, FEED_TIME_RST});
    rd(REG_MIX_TIME, {16'h0, MIX_TIME_RST});
    rd(REG_VIB_ON, {16'h0, VIB_ON_RST});
    rd(REG_VIB_OFF, {16'h0, VIB_OFF_RST});
    rd(REG_IRQ_MASK, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    wr(REG_FEED_TIME, 32'h3);
    wr(REG_MIX_TIME, 32'h2);
    wr(REG_VIB_ON, 32'h1);
    wr(REG_VIB_OFF, 32'h1);
    rd(REG_FEED_TIME, 32'h3);
    // system off with the tank at low level
    repeat (6) @(negedge i_clock);
    check(seen[2:0], 3'h0);
    check(o_feeder_speed, 8'h5a);
    @(posedge i_clock) i_speed_src <= 1;
    repeat (2) @(negedge i_clock);
    check(o_feeder_speed, 8'ha5);
    // automatic batch with a flow gap
    @(posedge i_clock) i_sys_sel <= SYS_ON;
    wait_out(0, 1, 3);
    wait_out(2, 1, 3);
    wait_out(1, 1, 3);
    feed_on = 0;
    ack();
    wait_out(4, 0, 3);
    @(posedge i_clock) supply <= 0;
    wait_out(1, 0, 3);
    wait_out(4, 1, 3);
    ack();
    repeat (3) @(negedge i_clock);
    check(o_alarm, 1'b1);
    @(posedge i_clock) supply <= 1;
    wait_out(1, 1, 3);
    ack();
    wait_out(4, 0, 3);
    wait_out(1, 0, 30);
    check(feed_on >= 11 && feed_on <= 17, 1);
    check({high, o_water_valve, o_mixer}, 3'h3);
    wait_out(5, 1, 80);
    wait_out(0, 0, 3);
    repeat (5) @(negedge i_clock);
    check({o_feeder, o_mixer}, 2'h1);
    wait_out(2, 0, 10);
    rd(REG_STATE, 32'h0003_0000);
    rd(REG_IRQ_STATUS, 32'h7);
    check(o_irq, 1'b0);
    wr(REG_IRQ_MASK, 32'hf);
    check(o_irq, 1'b1);
    wr(REG_IRQ_STATUS, 32'h7);
    rd(REG_IRQ_STATUS, 32'h0);
    check(o_irq, 1'b0);
    // hopper lamp leaves sequencing alone
    @(posedge i_clock) i_hopper_low <= 1;
    wait_out(7, 1, 3);
    check({o_irq, seen[2:0]}, 4'h8);
    @(posedge i_clock) i_hopper_low <= 0;
    wr(REG_IRQ_STATUS, 32'h8);
    // remote run contact
    // remote with the contact open, so the drained tank must not start a batch
    @(posedge i_clock) drain <= 1;
    i_sys_sel <= SYS_REMOTE;
    wait_out(6, 1, 80);
    @(posedge i_clock) drain <= 0;
    repeat (6) @(negedge i_clock);
    check(o_water_valve, 1'b0);
    @(posedge i_clock) i_run_contact <= 1;
    wait_out(0, 1, 3);
    @(posedge i_clock) i_run_contact <= 0;
    wait_out(0, 0, 3);
    // manual selectors with the system off
    @(posedge i_clock) i_sys_sel <= SYS_OFF;
    {i_water_sel, i_feeder_sel, i_mixer_sel, i_vib_sel} <= {4{SEL_ON}};
    for (int b = 0; b < 4; b++) wait_out(b, 1, 3);
    wait_out(5, 1, 80);
    repeat (3) @(negedge i_clock);
    check(seen[3:0], 4'hf);
    @(posedge i_clock) i_vib_sel <= SEL_AUTO;
    @(negedge i_clock);
    vib_hi = 0;
    vib_lo = 0;
    repeat (24) @(negedge i_clock);
    check(vib_hi >= 6 && vib_lo >= 6, 1);
    @(posedge i_clock) i_feeder_sel <= SEL_OFF;
    wait_out(1, 0, 3);
    wait_out(3, 0, 3);
    @(posedge i_clock) {i_water_sel, i_mixer_sel} <= {2{SEL_OFF}};
    wait_out(0, 0, 3);
    wait_out(2, 0, 3);
    repeat (2) @(negedge i_clock);
    give_verdict();
  end
endmodule // tb_batch_mix_sequencer
